// ### xba_crossbar_ctrl.v
/*
 * Crossbar control: ID formation, response steering, acceptance and issuing counters,
 * deadlock guard and rank arbitration for the write and read address channels, plus an APB slave.
 * Assumes all channels are synchronous to core_clk and that address decode is done upstream,
 * delivering each request's downstream target index alongside it.
 * Channel index 0 is write and 1 is read in every packed per-channel port.
 */
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "xba_consts.vh"
module xba_crossbar_ctrl #(
    parameter NSI = 4,
    parameter NMI = 2,
    parameter SIW = 2,
    parameter MIW = 1,
    parameter TW = 2,
    parameter IDW = 4,
    parameter [NSI*3-1:0] SLOT_THREAD_BITS = {3'd1, 3'd0, 3'd2, 3'd2},
    parameter [NSI*IDW-1:0] SLOT_TAG_BASE = {4'hA, 4'h8, 4'h4, 4'h0},
    parameter [NSI*`XBA_CNT_W-1:0] SLOT_WRITE_ACCEPT = {4'h4, 4'h4, 4'h4, 4'h4},
    parameter [NSI*`XBA_CNT_W-1:0] SLOT_READ_ACCEPT = {4'h4, 4'h4, 4'h4, 4'h4},
    parameter [NMI*`XBA_CNT_W-1:0] DOWN_WRITE_ISSUE = {4'h8, 4'h8},
    parameter [NMI*`XBA_CNT_W-1:0] DOWN_READ_ISSUE = {4'h8, 4'h8},
    parameter [NSI-1:0] SLOT_LITE = 4'h0,
    parameter [NMI-1:0] DOWN_LITE = 2'h0
) (
    input wire core_clk,
    input wire resetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`XBA_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    input wire [2*NSI-1:0] reqValid,
    input wire [2*NSI*MIW-1:0] reqTarget,
    input wire [2*NSI*TW-1:0] reqThread,
    output wire [2*NSI-1:0] reqGrant,
    input wire [1:0] issueReady,
    output reg [1:0] issueValid,
    output reg [2*IDW-1:0] issueTag,
    output reg [2*MIW-1:0] issueTarget,
    input wire [1:0] respValid,
    input wire [1:0] respReady,
    input wire [1:0] respLast,
    input wire [2*IDW-1:0] respTag,
    input wire [2*MIW-1:0] respSource,
    output wire [2*NSI-1:0] respSelect
);
    function [IDW-1:0] lowMask;
        input [2:0] bits;
        begin
            lowMask = ~({IDW{1'b1}} << bits);
        end
    endfunction

    function [2:0] threadBits;
        input integer s;
        begin
            threadBits = SLOT_THREAD_BITS[s*3 +: 3];
        end
    endfunction

    // The low base bits are forced clear, so a stray base bit can never alias a thread value.
    function [IDW-1:0] cleanBase;
        input integer s;
        begin
            cleanBase = SLOT_TAG_BASE[s*IDW +: IDW] & ~lowMask(threadBits(s));
        end
    endfunction

    // Flags a table whose ranges overlap or whose slots cannot all be told apart.
    function cfgFaultCalc;
        input integer dummy;
        integer a;
        integer b;
        reg [IDW-1:0] m;
        begin
            cfgFaultCalc = (dummy != 0);
            m = {IDW{1'b0}};
            for (a = 0; a < NSI; a = a + 1)
            begin
                if ((SLOT_TAG_BASE[a*IDW +: IDW] & lowMask(threadBits(a))) != 0)
                    cfgFaultCalc = 1'b1;
                for (b = a + 1; b < NSI; b = b + 1)
                begin
                    m = ~lowMask(threadBits(a)) & ~lowMask(threadBits(b));
                    if ((cleanBase(a) & m) == (cleanBase(b) & m))
                        cfgFaultCalc = 1'b1;
                end
            end
        end
    endfunction

    // Tracker count per slot; one per possible thread value, never more than acceptance.
    function [`XBA_CNT_W:0] trackDepth;
        input [`XBA_CNT_W-1:0] acc;
        input [2:0] bits;
        reg [`XBA_CNT_W:0] span;
        begin
            span = (bits >= `XBA_CNT_W) ? {1'b1, {`XBA_CNT_W{1'b0}}} : ({{`XBA_CNT_W{1'b0}}, 1'b1} << bits);
            trackDepth = ({1'b0, acc} < span) ? {1'b0, acc} : span;
        end
    endfunction

    localparam CFG_FAULT = 1'b0 | cfgFaultCalc(0);
    localparam [`XBA_CNT_W-1:0] LITE_LIMIT = 1;

    reg [NSI*`XBA_RANK_W-1:0] slotGrantRank;
    reg [`XBA_CNT_W-1:0] slotCount [0:2*NSI-1];
    reg [MIW-1:0] slotTarget [0:2*NSI-1];
    reg [`XBA_CNT_W-1:0] downCount [0:2*NMI-1];
    wire [1:0] chFound;
    wire [2*SIW-1:0] chWinner;
    wire [1:0] chFire;
    reg [NSI-1:0] eligible [0:1];
    reg [IDW-1:0] nextTag [0:1];
    reg [MIW-1:0] nextTarget [0:1];

    genvar ch;
    genvar gs;
    genvar gm;
    generate
        for (ch = 0; ch < 2; ch = ch + 1)
        begin : chan
            wire respFire = respValid[ch] & respReady[ch];
            // A write ends on its response; a read only on the beat marked last.
            wire respDone = respFire & (respLast[ch] | (ch == `XBA_CH_WRITE));
            wire [MIW-1:0] respMi = respSource[ch*MIW +: MIW];
            wire [SIW-1:0] win = chWinner[ch*SIW +: SIW];
            integer s;
            integer t;
            reg [MIW-1:0] tgt;
            reg [`XBA_CNT_W-1:0] lim;
            reg [`XBA_CNT_W-1:0] dlim;
            reg [TW-1:0] thr;
            reg [IDW-1:0] thrWide;

            always @*
            begin
                eligible[ch] = {NSI{1'b0}};
                tgt = {MIW{1'b0}};
                lim = {`XBA_CNT_W{1'b0}};
                dlim = {`XBA_CNT_W{1'b0}};
                for (s = 0; s < NSI; s = s + 1)
                begin
                    tgt = reqTarget[(ch*NSI+s)*MIW +: MIW];
                    lim = (ch == `XBA_CH_WRITE) ? SLOT_WRITE_ACCEPT[s*`XBA_CNT_W +: `XBA_CNT_W]
                        : SLOT_READ_ACCEPT[s*`XBA_CNT_W +: `XBA_CNT_W];
                    if (SLOT_LITE[s])
                        lim = LITE_LIMIT;
                    dlim = (ch == `XBA_CH_WRITE) ? DOWN_WRITE_ISSUE[tgt*`XBA_CNT_W +: `XBA_CNT_W]
                        : DOWN_READ_ISSUE[tgt*`XBA_CNT_W +: `XBA_CNT_W];
                    if (DOWN_LITE[tgt])
                        dlim = LITE_LIMIT;
                    // Only counts held here are compared; upstream or downstream buffers are not seen.
                    eligible[ch][s] = reqValid[ch*NSI+s]
                        & (slotCount[ch*NSI+s] < lim)
                        & (downCount[ch*NMI+tgt] < dlim)
                        // The guard is kept per slot rather than per thread: safe, but a slot
                        // with two threads bound for different targets serialises them.
                        & (slotCount[ch*NSI+s] == 0 || slotTarget[ch*NSI+s] == tgt);
                end
            end

            xba_grant_arbiter #(
                .NSI(NSI),
                .IW(SIW)
            ) arb (
                .core_clk(core_clk),
                .resetn(resetn),
                .req(eligible[ch]),
                .ranks(slotGrantRank),
                .fire(chFire[ch]),
                .found(chFound[ch]),
                .winner(chWinner[ch*SIW +: SIW])
            );

            assign chFire[ch] = chFound[ch] & issueReady[ch];

            always @*
            begin
                thr = reqThread[(ch*NSI+win)*TW +: TW];
                thrWide = {IDW{1'b0}};
                thrWide[TW-1:0] = thr;
                nextTag[ch] = {IDW{1'b0}};
                // A loop index of its own: sharing one with the eligibility process would
                // let each process retrigger the other without end.
                for (t = 0; t < NSI; t = t + 1)
                begin
                    if (win == t)
                        nextTag[ch] = cleanBase(t) | (thrWide & lowMask(threadBits(t)));
                end
                nextTarget[ch] = reqTarget[(ch*NSI+win)*MIW +: MIW];
            end

            for (gs = 0; gs < NSI; gs = gs + 1)
            begin : slot
                wire inc = chFire[ch] && win == gs;
                // The upper tag bits name the slot; a cascaded feed is matched the same way.
                wire dec = respDone && ((respTag[ch*IDW +: IDW] & ~lowMask(threadBits(gs)))
                    == cleanBase(gs));
                assign reqGrant[ch*NSI+gs] = inc;
                assign respSelect[ch*NSI+gs] = respValid[ch]
                    && ((respTag[ch*IDW +: IDW] & ~lowMask(threadBits(gs))) == cleanBase(gs));
                always @(posedge core_clk)
                begin
                    if (!resetn)
                    begin
                        slotCount[ch*NSI+gs] <= {`XBA_CNT_W{1'b0}};
                        slotTarget[ch*NSI+gs] <= {MIW{1'b0}};
                    end
                    else
                    begin
                        if (inc && !dec)
                            slotCount[ch*NSI+gs] <= slotCount[ch*NSI+gs] + 1'b1;
                        else if (dec && !inc)
                            slotCount[ch*NSI+gs] <= slotCount[ch*NSI+gs] - 1'b1;
                        if (inc)
                            slotTarget[ch*NSI+gs] <= nextTarget[ch];
                    end
                end
            end

            for (gm = 0; gm < NMI; gm = gm + 1)
            begin : down
                wire inc = chFire[ch] && nextTarget[ch] == gm;
                wire dec = respDone && respMi == gm;
                always @(posedge core_clk)
                begin
                    if (!resetn)
                        downCount[ch*NMI+gm] <= {`XBA_CNT_W{1'b0}};
                    else if (inc && !dec)
                        downCount[ch*NMI+gm] <= downCount[ch*NMI+gm] + 1'b1;
                    else if (dec && !inc)
                        downCount[ch*NMI+gm] <= downCount[ch*NMI+gm] - 1'b1;
                end
            end

            always @(posedge core_clk)
            begin
                if (!resetn)
                begin
                    issueValid[ch] <= 1'b0;
                    issueTag[ch*IDW +: IDW] <= {IDW{1'b0}};
                    issueTarget[ch*MIW +: MIW] <= {MIW{1'b0}};
                end
                else
                begin
                    issueValid[ch] <= chFire[ch];
                    if (chFire[ch])
                    begin
                        issueTag[ch*IDW +: IDW] <= nextTag[ch];
                        issueTarget[ch*MIW +: MIW] <= nextTarget[ch];
                    end
                end
            end
        end
    endgenerate

    // APB slave: zero wait states, read data captured in the setup cycle.
    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire mapped = paddr == `XBA_REG_RANK || paddr == `XBA_REG_WOUT
        || paddr == `XBA_REG_ROUT || paddr == `XBA_REG_STAT;
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    reg [31:0] next_prdata;
    reg [3:0] depthSum;
    integer j;
    always @*
    begin
        next_prdata = 32'h0000_0000;
        depthSum = 4'h0;
        for (j = 0; j < NSI; j = j + 1)
        begin
            if (trackDepth(SLOT_READ_ACCEPT[j*`XBA_CNT_W +: `XBA_CNT_W], threadBits(j)) > 1)
                depthSum = depthSum + 1'b1;
        end
        case (paddr)
            `XBA_REG_RANK:
                next_prdata[NSI*`XBA_RANK_W-1:0] = slotGrantRank;
            `XBA_REG_WOUT:
                for (j = 0; j < NSI; j = j + 1)
                    next_prdata[j*`XBA_CNT_W +: `XBA_CNT_W] = slotCount[`XBA_CH_WRITE*NSI+j];
            `XBA_REG_ROUT:
                for (j = 0; j < NSI; j = j + 1)
                    next_prdata[j*`XBA_CNT_W +: `XBA_CNT_W] = slotCount[`XBA_CH_READ*NSI+j];
            `XBA_REG_STAT:
                next_prdata = {24'h00_0000, depthSum, 3'h0, CFG_FAULT};
            default:
                next_prdata = 32'h0000_0000;
        endcase
    end

    always @(posedge core_clk)
    begin
        if (!resetn)
        begin
            prdata <= 32'h0000_0000;
            slotGrantRank <= `XBA_RANK_RST;
        end
        else
        begin
            if (setup && !pwrite)
                prdata <= next_prdata;
            if (access && pwrite && paddr == `XBA_REG_RANK)
                slotGrantRank <= pwdata[NSI*`XBA_RANK_W-1:0];
        end
    end
endmodule // xba_crossbar_ctrl
`default_nettype wire

// ### xba_consts.vh
/*
 * Shared constants of the crossbar control block: register offsets, field widths and reset values.
 * Assumes it is included by bare name and that APB addresses are byte addresses.
 */
//
// Behaviour
// - Responses steered back by their transaction ID.
// - Thread bits form the low ID bits.
// - Single-depth master has no thread bits.
// - Full ID is base OR thread bits.
// - Base low bits cleared; upper bits name master.
// - ID width distinguishes every slave-side slot.
// - Response decode matches base and thread width.
// - Cascaded IDs become thread bits, prefixed.
// - ID ranges aligned, power-of-two, non-overlapping.
// - Per-slot write and read acceptance limits.
// - Trackers sized by min(acceptance, 2^threadbits).
// - Per-downstream-slot write and read issuing limits.
// - Counts cover only crossbar-held transactions.
// - Write count drops on response handshake.
// - Read count drops on last-beat handshake.
// - Slots at a limit leave arbitration.
// - Lite slots allow one outstanding transaction.
// - Highest static rank 0..15 wins.
// - All rank zero: round-robin choice.
// - Tied nonzero rank: lowest slot wins.
// - Deadlock-risking slot temporarily excluded.
// - One target per slot thread at once.
`ifndef XBA_CONSTS_VH
`define XBA_CONSTS_VH
`define XBA_ADDR_W 8
`define XBA_REG_RANK 8'h00
`define XBA_REG_WOUT 8'h04
`define XBA_REG_ROUT 8'h08
`define XBA_REG_STAT 8'h0C
`define XBA_RANK_W 4
`define XBA_CNT_W 4
`define XBA_RANK_RST 16'h0000
`define XBA_CH_WRITE 0
`define XBA_CH_READ 1
`endif

// ### xba_grant_arbiter.v
/*
 * Static-rank arbiter with a round-robin fallback for rank zero.
 * Assumes requests are already qualified and that a grant is used in the cycle it is shown.
 */
`timescale 1ns/100ps
`default_nettype none
`include "xba_consts.vh"
module xba_grant_arbiter #(
    parameter NSI = 4,
    parameter IW = 2
) (
    input wire core_clk,
    input wire resetn,
    input wire [NSI-1:0] req,
    input wire [NSI*`XBA_RANK_W-1:0] ranks,
    input wire fire,
    output reg found,
    output reg [IW-1:0] winner
);
    reg [IW-1:0] rrPtr;
    reg [`XBA_RANK_W-1:0] best;
    reg [`XBA_RANK_W-1:0] r;
    reg [IW:0] k;
    integer i;
    always @*
    begin
        best = {`XBA_RANK_W{1'b0}};
        found = 1'b0;
        winner = {IW{1'b0}};
        r = {`XBA_RANK_W{1'b0}};
        k = {(IW+1){1'b0}};
        for (i = 0; i < NSI; i = i + 1)
        begin
            r = ranks[i*`XBA_RANK_W +: `XBA_RANK_W];
            if (req[i] && r > best)
                best = r;
        end
        if (best != {`XBA_RANK_W{1'b0}})
        begin
            for (i = NSI - 1; i >= 0; i = i - 1)
            begin
                r = ranks[i*`XBA_RANK_W +: `XBA_RANK_W];
                if (req[i] && r == best)
                begin
                    found = 1'b1;
                    winner = i[IW-1:0];
                end
            end
        end
        else
        begin
            // Search from the pointer upward so each slot waits at most NSI-1 grants.
            for (i = NSI - 1; i >= 0; i = i - 1)
            begin
                k = {1'b0, rrPtr} + i[IW:0];
                if (k >= NSI)
                    k = k - NSI[IW:0];
                if (req[k[IW-1:0]])
                begin
                    found = 1'b1;
                    winner = k[IW-1:0];
                end
            end
        end
    end
    always @(posedge core_clk)
    begin
        if (!resetn)
            rrPtr <= {IW{1'b0}};
        else if (fire && best == {`XBA_RANK_W{1'b0}})
            rrPtr <= (winner == NSI - 1) ? {IW{1'b0}} : winner + 1'b1;
    end
endmodule // xba_grant_arbiter
`default_nettype wire

// ### xba_ctrl_properties.sv
/* Port assertions for the crossbar control block.
   Assumes the default parameters: tag bases 0,4,8,A and thread widths 2,2,0,1. */
`timescale 1ns/100ps
`default_nettype none
module xba_ctrl_properties (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [7:0] reqValid,
    input wire logic [15:0] reqThread,
    input wire logic [7:0] reqGrant,
    input wire logic [1:0] issueReady,
    input wire logic [1:0] issueValid,
    input wire logic [7:0] issueTag,
    input wire logic [1:0] respValid,
    input wire logic [7:0] respTag,
    input wire logic [7:0] respSelect
);
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_write_issue_follows: assert property (|reqGrant[3:0] |=> issueValid[0])
        else $error("write grant gave no issue");
    a_read_issue_follows: assert property (|reqGrant[7:4] |=> issueValid[1])
        else $error("read grant gave no issue");
    a_no_stray_issue: assert property (!(|reqGrant[3:0]) |=> !issueValid[0])
        else $error("write issue without grant");
    a_grant_one_hot: assert property ($onehot0(reqGrant[3:0]) && $onehot0(reqGrant[7:4]))
        else $error("more than one grant");
    a_grant_needs_request: assert property ((reqGrant & ~reqValid) == 8'h00)
        else $error("grant without request");
    a_grant_needs_ready: assert property (|reqGrant[3:0] |-> issueReady[0])
        else $error("grant while downstream busy");
    a_thread_low_bits: assert property (reqGrant[0] |=> issueTag[3:0] == {2'b00, $past(reqThread[1:0])})
        else $error("slot 0 tag wrong");
    a_fixed_slot_tag: assert property (reqGrant[2] |=> issueTag[3:0] == 4'h8)
        else $error("slot 2 tag wrong");
    a_or_base_tag: assert property (reqGrant[7] |=> issueTag[7:4] == {3'b101, $past(reqThread[14])})
        else $error("slot 3 read tag wrong");
    a_steer_decode: assert property (respValid[0] && respTag[3:2] == 2'b01 |-> respSelect[3:0] == 4'h2)
        else $error("response not steered to slot 1");
    a_steer_gated: assert property (!respValid[1] |-> respSelect[7:4] == 4'h0)
        else $error("read select without response");
endmodule // xba_ctrl_properties
bind xba_crossbar_ctrl xba_ctrl_properties chk_u (.core_clk, .resetn, .reqValid, .reqThread,
    .reqGrant, .issueReady, .issueValid, .issueTag, .respValid, .respTag, .respSelect);
`default_nettype wire

// ### xba_down_model.sv
/* Downstream slave model: takes every issue, answers in order with one write response or
   two read beats. Assumes hold is raised only while nothing waits to be answered. */
`timescale 1ns/100ps
`default_nettype none
module xba_down_model (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic hold,
    input wire logic [1:0] stall,
    input wire logic [1:0] issueValid,
    input wire logic [7:0] issueTag,
    input wire logic [1:0] issueTarget,
    input wire logic [1:0] respReady,
    output logic [1:0] issueReady,
    output logic [1:0] respValid,
    output logic [1:0] respLast,
    output logic [7:0] respTag,
    output logic [1:0] respSource
);
    logic [4:0] q[2][$];
    logic rb;
    assign issueReady = ~stall;
    // Idle respTag shows the inverse of its last value, never a stale match; respSource does so only once its queue is empty.
    always @(posedge core_clk)
    begin
        if (!resetn)
        begin
            q[0].delete();
            q[1].delete();
            rb = 1'b0;
            respValid <= 2'b00;
            respTag <= 8'h00;
        end
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                if (respValid[c] && respReady[c])
                begin
                    if (c == 0 || rb)
                        void'(q[c].pop_front());
                    if (c == 1)
                        rb = !rb;
                end
                if (issueValid[c])
                    q[c].push_back({issueTarget[c], issueTag[c*4+:4]});
                respValid[c] <= !hold && q[c].size() > 0;
                respTag[c*4+:4] <= (!hold && q[c].size() > 0) ? q[c][0][3:0] : ~respTag[c*4+:4];
                respSource[c] <= q[c].size() > 0 ? q[c][0][4] : ~respSource[c];
            end
            respLast <= {rb, 1'b1};
        end
    end
endmodule // xba_down_model
`default_nettype wire

// ### tb_crossbar_id_limit_arbiter.sv
/* Self-checking bench of the crossbar control block with a downstream slave model.
   Assumes the default parameters of the block. */
`timescale 1ns/100ps
`default_nettype none
module tb_crossbar_id_limit_arbiter;
    logic core_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic hold = 1'b0, stallOn = 1'b0, e;
    logic [7:0] paddr = 8'h00, reqValid = 8'h00, reqTarget = 8'h00;
    logic [15:0] reqThread = 16'h0000;
    logic [31:0] pwdata = 32'h0, prdata, r, v, seed = 32'h0001_0E87;
    logic [1:0] respReady = 2'h0, stall = 2'h0;
    logic pready, pslverr;
    logic [7:0] reqGrant, issueTag, respTag, respSelect;
    logic [1:0] issueReady, issueValid, issueTarget, respValid, respLast, respSource;
    logic [3:0] expQ[2][$];
    logic [1:0] thr[4];
    int num_errors = 0, check_count = 0, gcnt[8];
    xba_crossbar_ctrl dut_u (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .reqValid, .reqTarget, .reqThread, .reqGrant, .issueReady,
        .issueValid, .issueTag, .issueTarget, .respValid, .respReady, .respLast, .respTag,
        .respSource, .respSelect);
    xba_down_model far_u (.core_clk, .resetn, .hold, .stall, .issueValid, .issueTag,
        .issueTarget, .respReady, .issueReady, .respValid, .respLast, .respTag, .respSource);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [3:0] tagOf(int s);
        case (s)
            0: return {2'b00, thr[0]};
            1: return {2'b01, thr[1]};
            2: return 4'h8;
            default: return {3'b101, thr[3][0]};
        endcase
    endfunction
    function automatic logic [3:0] slotOf(logic [3:0] t);
        return t[3] ? (t[1] ? 4'h8 : 4'h4) : (t[2] ? 4'h2 : 4'h1);
    endfunction
    task automatic chk(string n, logic [31:0] x, logic [31:0] y);
        check_count++;
        if (y !== x)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, x, y);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do
            @(posedge core_clk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic pick(int ch);
        for (int s = 0; s < 4; s++)
        begin
            thr[s] = 2'(rnd());
            // Both channels get the same thread values, so one tag table serves both.
            reqThread[(ch*4+s)*2+:2] <= thr[s];
            reqThread[((1-ch)*4+s)*2+:2] <= thr[s];
        end
    endtask
    task automatic want(int ch, int s, int n);
        repeat (n) expQ[ch].push_back(tagOf(s));
    endtask
    // Keep holds the requests past their grants, to run into the limits.
    task automatic burst(int ch, logic [3:0] m, logic tg, int n, logic keep);
        @(posedge core_clk);
        reqTarget[ch*4+:4] <= {4{tg}};
        reqValid[ch*4+:4] <= m;
        for (int i = n; i > 0; i--)
        begin
            @(posedge core_clk);
            reqValid[ch*4+:4] <= (i == 1) ? 4'h0 : keep ? m : reqValid[ch*4+:4] & ~reqGrant[ch*4+:4];
        end
    endtask
    initial
    begin
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        v = rnd();
        stall <= stallOn ? v[1:0] : 2'b00;
        respReady <= v[3:2];
        for (int i = 0; i < 8; i++)
            if (reqGrant[i] === 1'b1)
                gcnt[i]++;
        for (int c = 0; c < 2; c++)
        begin
            if (issueValid[c] === 1'b1)
            begin
                chk("issue tag", expQ[c].size() > 0 ? expQ[c].pop_front() : 4'hX, issueTag[c*4+:4]);
                chk("issue target", reqTarget[c*4], issueTarget[c]);
            end
            if (respValid[c] === 1'b1)
                chk("steer", slotOf(respTag[c*4+:4]), respSelect[c*4+:4]);
        end
    end
    initial
    begin
        repeat (5000) @(posedge core_clk);
        num_errors++;
        $display("Error watchdog expected finish seen timeout");
        summarize();
    end
    initial
    begin
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        apb(1'b0, 8'h00, 32'h0);
        chk("rank reset", 32'h0, r);
        apb(1'b1, 8'h04, 32'hFFFF_FFFF);
        apb(1'b0, 8'h04, 32'h0);
        chk("write counts", 32'h0, r);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, e});
        apb(1'b1, 8'h00, 32'h7550);
        apb(1'b0, 8'h00, 32'h0);
        chk("rank", 32'h7550, r);
        apb(1'b0, 8'h0C, 32'h0);
        chk("status", 32'h30, r);
        $display("registers done");
        stallOn <= 1'b1;
        pick(0);
        want(0, 3, 1);
        want(0, 1, 1);
        want(0, 2, 1);
        want(0, 0, 1);
        burst(0, 4'hF, 1'b0, 24, 1'b0);
        apb(1'b1, 8'h00, 32'h0);
        pick(1);
        want(1, 1, 1);
        burst(1, 4'h2, 1'b1, 12, 1'b0);
        want(1, 2, 1);
        want(1, 3, 1);
        want(1, 0, 1);
        want(1, 1, 1);
        burst(1, 4'hF, 1'b1, 24, 1'b0);
        while (far_u.q[0].size() + far_u.q[1].size() != 0) @(posedge core_clk);
        $display("arbitration done");
        stallOn <= 1'b0;
        hold <= 1'b1;
        apb(1'b1, 8'h00, 32'h0123);
        gcnt = '{default:0};
        want(0, 0, 4);
        want(0, 1, 4);
        burst(0, 4'hB, 1'b0, 14, 1'b1);
        chk("slot 3 grants", 0, gcnt[3]);
        apb(1'b0, 8'h04, 32'h0);
        chk("write counts", 32'h44, r);
        want(1, 0, 1);
        burst(1, 4'h1, 1'b0, 4, 1'b0);
        burst(1, 4'h1, 1'b1, 6, 1'b1);
        chk("guarded grants", 1, gcnt[4]);
        $display("limits done");
        pick(0);
        want(0, 3, 1);
        hold <= 1'b0;
        burst(0, 4'h8, 1'b0, 30, 1'b0);
        pick(1);
        want(1, 0, 1);
        burst(1, 4'h1, 1'b1, 30, 1'b0);
        while (far_u.q[0].size() + far_u.q[1].size() != 0) @(posedge core_clk);
        apb(1'b0, 8'h04, 32'h0);
        chk("write counts idle", 32'h0, r);
        apb(1'b0, 8'h08, 32'h0);
        chk("read counts idle", 32'h0, r);
        chk("pending issues", 0, expQ[0].size() + expQ[1].size());
        $display("release done");
        summarize();
    end
endmodule // tb_crossbar_id_limit_arbiter
`default_nettype wire
